/* hw/dmacl_pkg.sv */
// Purpose: constants for the dma channel control and last address block
// Assumes: axi4-lite slave, 32-bit data, 8-bit byte addresses
// Notes: narrow registers sit in the low bits, upper bits read zero
package dmacl_pkg;
  // =====================================================
  // bus and register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BUFA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BUFB = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PERI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_LAST_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_LAST_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h1c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =====================================================
  // control word fields
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_DIR_BIT = 13;
  localparam int CTRL_HALF_BIT = 12;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [15:0] CTRL_WR_MASK = 16'hb003;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] LAST_RESET = 16'h0000;
  // =====================================================
  // operating modes
  typedef enum logic [1:0] {
    DMACL_CONT_SINGLE = 2'b00,
    DMACL_ONESHOT_SINGLE = 2'b01,
    DMACL_CONT_PINGPONG = 2'b10,
    DMACL_ONESHOT_PINGPONG = 2'b11
  } dmacl_mode_e;
  // =====================================================
  // datapath widths
  localparam int RAM_AW = 24;
  localparam int PERI_AW = 16;
  localparam int WORD_W = 16;
  localparam int CNT_W = 16;
  localparam int BUF_W = RAM_AW + WORD_W;
  localparam int BUF_DEPTH = 2;
endpackage

/* hw/dmacl_buf_if.sv */
// Purpose: push and pop handshake bundle around the staging buffer
// Assumes: single clock, valid/ready on both sides
// Notes: payload is ram address over data word
`timescale 1ns/1ps
interface dmacl_buf_if #(parameter int W = 40);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fifo (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

/* hw/dmacl_buf.sv */
// Purpose: small fifo staging words between source and destination
// Assumes: depth is a power of two
// Notes: ready and valid come straight from the fill count
`timescale 1ns/1ps
module dmacl_buf #(
  parameter int W = 40,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  dmacl_buf_if.fifo b
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  wire push_fire = b.push_valid && b.push_ready;
  wire pop_fire = b.pop_valid && b.pop_ready;
  assign b.push_ready = (cnt_q != (PW+1)'(DEPTH));
  assign b.pop_valid = (cnt_q != '0);
  assign b.pop_data = mem_q[rd_q];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push_fire)
        wr_q <= wr_q + 1'b1;
      if (pop_fire)
        rd_q <= rd_q + 1'b1;
      if (push_fire && !pop_fire)
        cnt_q <= cnt_q + 1'b1;
      else if (pop_fire && !push_fire)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push_fire)
      mem_q[wr_q] <= b.push_data;
  end
endmodule // dmacl_buf

/* hw/dmacl_top.sv */
// Purpose: one dma channel with control word and last address record
// Assumes: source and destination are valid/ready streams
// Notes: block length register holds word count minus one
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dmacl_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [dmacl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [dmacl_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [dmacl_pkg::ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [dmacl_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [dmacl_pkg::WORD_W-1:0] src_data_i,
  output logic [dmacl_pkg::RAM_AW-1:0] src_addr_o,
  output logic src_is_ram_o,
  output logic dst_valid_o,
  input wire logic dst_ready_i,
  output logic [dmacl_pkg::WORD_W-1:0] dst_data_o,
  output logic [dmacl_pkg::RAM_AW-1:0] dst_addr_o,
  output logic dst_is_ram_o,
  output logic block_event_o
);
  import dmacl_pkg::*;

  // =====================================================
  // registers
  logic [15:0] ctrl_q;
  logic [RAM_AW-1:0] bufa_q;
  logic [RAM_AW-1:0] bufb_q;
  logic [PERI_AW-1:0] peri_q;
  logic [CNT_W-1:0] len_q;
  logic [RAM_AW-1:0] last_q;
  logic [CNT_W-1:0] src_cnt_q;
  logic [CNT_W-1:0] dst_cnt_q;
  logic src_done_q;
  logic pp_q;
  logic event_q;

  // =====================================================
  // axi write channel
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  assign s_axi_awready_o = !aw_held_q && !bvalid_q;
  assign s_axi_wready_o = !w_held_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire [5:0] wr_idx = awaddr_q[7:2];
  wire wr_ctrl = wr_go && (wr_idx == OFF_CTRL[7:2]);
  wire wr_bufa = wr_go && (wr_idx == OFF_BUFA[7:2]);
  wire wr_bufb = wr_go && (wr_idx == OFF_BUFB[7:2]);
  wire wr_peri = wr_go && (wr_idx == OFF_PERI[7:2]);
  wire wr_cnt = wr_go && (wr_idx == OFF_CNT[7:2]);
  // last address and status are read-only, writes just answer okay
  wire wr_ro = (wr_idx == OFF_LAST_HI[7:2]) ||
               (wr_idx == OFF_LAST_LO[7:2]) || (wr_idx == OFF_STAT[7:2]);
  wire wr_hit = wr_ctrl || wr_bufa || wr_bufb || wr_peri || wr_cnt || wr_ro;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  wire [31:0] ctrl_m = merge({16'h0000, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] bufa_m = merge({8'h00, bufa_q}, wdata_q, wstrb_q);
  wire [31:0] bufb_m = merge({8'h00, bufb_q}, wdata_q, wstrb_q);
  wire [31:0] peri_m = merge({16'h0000, peri_q}, wdata_q, wstrb_q);
  wire [31:0] cnt_m = merge({16'h0000, len_q}, wdata_q, wstrb_q);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  // =====================================================
  // axi read channel
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  wire [5:0] rd_idx = s_axi_araddr_i[7:2];
  wire [31:0] last_hi_w = {24'h000000, last_q[23:16]};
  wire [31:0] last_lo_w = {16'h0000, last_q[15:0]};
  wire [31:0] stat_w = {29'h0, src_done_q, pp_q, ctrl_q[CTRL_EN_BIT]};
  wire rd_hit = (rd_idx <= OFF_STAT[7:2]);
  wire [31:0] rd_mux =
    (rd_idx == OFF_CTRL[7:2]) ? {16'h0000, ctrl_q} :
    (rd_idx == OFF_BUFA[7:2]) ? {8'h00, bufa_q} :
    (rd_idx == OFF_BUFB[7:2]) ? {8'h00, bufb_q} :
    (rd_idx == OFF_PERI[7:2]) ? {16'h0000, peri_q} :
    (rd_idx == OFF_CNT[7:2]) ? {16'h0000, len_q} :
    (rd_idx == OFF_LAST_HI[7:2]) ? last_hi_w :
    (rd_idx == OFF_LAST_LO[7:2]) ? last_lo_w :
    (rd_idx == OFF_STAT[7:2]) ? stat_w : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready_i)
      rvalid_q <= 1'b0;
  end

  // =====================================================
  // channel datapath
  dmacl_buf_if #(.W(BUF_W)) bif ();
  dmacl_buf #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .b(bif)
  );

  wire en = ctrl_q[CTRL_EN_BIT];
  wire dir = ctrl_q[CTRL_DIR_BIT];
  wire half_sel = ctrl_q[CTRL_HALF_BIT];
  wire [1:0] mode = ctrl_q[CTRL_MODE_LSB +: 2];
  wire [RAM_AW-1:0] base = pp_q ? bufb_q : bufa_q;
  wire [RAM_AW-1:0] ram_addr = base + RAM_AW'({src_cnt_q, 1'b0});
  wire [RAM_AW-1:0] peri_ext = {8'h00, peri_q};
  wire [RAM_AW-1:0] pop_addr = bif.pop_data[BUF_W-1 -: RAM_AW];

  assign src_ready_o = en && !src_done_q && bif.push_ready;
  assign src_is_ram_o = dir;
  assign src_addr_o = dir ? ram_addr : peri_ext;
  assign dst_is_ram_o = !dir;
  assign dst_addr_o = dir ? peri_ext : pop_addr;
  assign dst_data_o = bif.pop_data[WORD_W-1:0];
  assign dst_valid_o = bif.pop_valid;
  assign bif.push_valid = src_valid_i && en && !src_done_q;
  assign bif.push_data = {ram_addr, src_data_i};
  assign bif.pop_ready = dst_ready_i;
  assign block_event_o = event_q;

  wire src_fire = src_valid_i && src_ready_o;
  wire dst_fire = bif.pop_valid && dst_ready_i;
  wire [CNT_W:0] half_mark = ({1'b0, len_q} + 1'b1) >> 1;
  wire [CNT_W:0] moved = {1'b0, dst_cnt_q} + 1'b1;
  wire block_end = en && dst_fire && (dst_cnt_q == len_q);
  wire hit_half = en && dst_fire && (moved == half_mark);
  // one-shot ping-pong stops after the second buffer
  wire stop = (mode == DMACL_ONESHOT_SINGLE) ||
              ((mode == DMACL_ONESHOT_PINGPONG) && pp_q);
  wire pp_flip = mode[1];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= CTRL_RESET;
      bufa_q <= '0;
      bufb_q <= '0;
      peri_q <= '0;
      len_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_m[15:0] & CTRL_WR_MASK;
      else if (block_end && stop)
        ctrl_q[CTRL_EN_BIT] <= 1'b0;
      if (wr_bufa)
        bufa_q <= bufa_m[RAM_AW-1:0];
      if (wr_bufb)
        bufb_q <= bufb_m[RAM_AW-1:0];
      if (wr_peri)
        peri_q <= peri_m[PERI_AW-1:0];
      if (wr_cnt)
        len_q <= cnt_m[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !en)
    begin
      src_cnt_q <= '0;
      dst_cnt_q <= '0;
      src_done_q <= 1'b0;
      pp_q <= 1'b0;
    end
    else if (block_end)
    begin
      src_cnt_q <= '0;
      dst_cnt_q <= '0;
      src_done_q <= 1'b0;
      pp_q <= pp_flip ? !pp_q : 1'b0;
    end
    else
    begin
      if (src_fire)
      begin
        src_cnt_q <= src_cnt_q + 1'b1;
        src_done_q <= (src_cnt_q == len_q);
      end
      if (dst_fire)
        dst_cnt_q <= dst_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      event_q <= 1'b0;
      last_q <= {LAST_RESET[7:0], LAST_RESET};
    end
    else
    begin
      event_q <= half_sel ? hit_half : block_end;
      if (dir && src_fire)
        last_q <= ram_addr;
      else if (!dir && dst_fire)
        last_q <= pop_addr;
    end
  end
endmodule // dmacl_top

/* dv/dmacl_properties.sv */
// Purpose: port checks for the dma channel
// Assumes: one clock, sync reset
// Notes: bound into dmacl_top
`timescale 1ns/1ps
module dmacl_properties
  import dmacl_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [DATA_W-1:0] s_axi_rdata_o,
  input wire logic dst_valid_o,
  input wire logic dst_ready_i,
  input wire logic [WORD_W-1:0] dst_data_o,
  input wire logic [RAM_AW-1:0] dst_addr_o,
  input wire logic [RAM_AW-1:0] src_addr_o,
  input wire logic src_is_ram_o,
  input wire logic dst_is_ram_o,
  input wire logic block_event_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // ==================================================
  // checks
  ev_pulse_a: assert property (block_event_o |=> !block_event_o)
    else $error("event pulse too long");
  ev_cause_a: assert property (block_event_o |->
    $past(dst_valid_o) && $past(dst_ready_i))
    else $error("event without a moved word");
  dir_swap_a: assert property (src_is_ram_o != dst_is_ram_o)
    else $error("both sides on one bus");
  peri_src_a: assert property (!src_is_ram_o |->
    src_addr_o[23:16] == 8'h00)
    else $error("peripheral source too wide");
  dst_hold_a: assert property (dst_valid_o && !dst_ready_i |=>
    dst_valid_o && $stable(dst_data_o) && $stable(dst_addr_o))
    else $error("stalled word changed");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o)
    else $error("read not answered");
  hi_zero_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i == OFF_LAST_HI |=> s_axi_rdata_o[31:8] == 24'h0)
    else $error("high record upper bits set");
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  rst_quiet_a: assert property ($fell(reset_i) |->
    !dst_valid_o && !block_event_o && !s_axi_rvalid_o)
    else $error("outputs busy after reset");
  cover property (block_event_o);
  cover property (dst_valid_o && !dst_ready_i);
  cover property (s_axi_arvalid_i && s_axi_araddr_i == OFF_LAST_LO);
endmodule // dmacl_properties
bind dmacl_top dmacl_properties u_props (.clk_i(clk_i), .reset_i(reset_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .dst_valid_o(dst_valid_o), .dst_ready_i(dst_ready_i),
  .dst_data_o(dst_data_o), .dst_addr_o(dst_addr_o),
  .src_addr_o(src_addr_o), .src_is_ram_o(src_is_ram_o),
  .dst_is_ram_o(dst_is_ram_o), .block_event_o(block_event_o));

/* dv/dmacl_far.sv */
// Purpose: source and sink standing at the channel's far side
// Assumes: load only while idle
// Notes: random pacing and random sink stalls
`timescale 1ns/1ps
module dmacl_far (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [7:0] count_i,
  input wire logic src_ready_i,
  output logic src_valid_o,
  output logic [15:0] src_data_o,
  output logic dst_ready_o,
  output logic [7:0] left_o
);
  logic [7:0] rem;
  assign rem = left_o - 8'(src_valid_o && src_ready_i);
  // data wanders every cycle unless a word is held
  always_ff @(posedge clk_i)
  begin
    dst_ready_o <= ($urandom % 4) != 0;
    src_data_o <= (src_valid_o && !src_ready_i) ? src_data_o
      : 16'($urandom);
    if (reset_i)
    begin
      left_o <= 8'h00;
      src_valid_o <= 1'b0;
    end
    else if (load_i)
      left_o <= count_i;
    else if (!src_valid_o || src_ready_i)
    begin
      left_o <= rem;
      src_valid_o <= rem != 8'h00 && $urandom % 2 == 1;
    end
  end
endmodule // dmacl_far

/* dv/dmacl_top_test.sv */
// Purpose: self-checking bench for the dma channel
// Assumes: four word blocks
// Notes: watchers run on the falling edge
`timescale 1ns/1ps
module dmacl_top_test;
  import dmacl_pkg::*;
  logic clk_i = 0, reset_i = 1, ld = 0, awv = 0, wv = 0, bre = 0;
  logic arv = 0, rre = 0, awr, wr_, bv, arr, rv, sv, sr, dv, dre, ev;
  logic dir, half, sir, dri;
  logic [7:0] awa = 0, ara = 0, cnt = 0, left;
  logic [31:0] wd = 0, rdat;
  logic [1:0] br, rr;
  logic [15:0] sd, dd;
  logic [23:0] sa, da, la, ba, bb, pa;
  logic [23:0] aq[$];
  logic [15:0] dq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0, comparisons = 0, mv, evn, n, k;
  always #10 clk_i = ~clk_i;
  dmacl_top DUT (.clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .src_valid_i(sv),
    .src_ready_o(sr), .src_data_i(sd), .src_addr_o(sa),
    .src_is_ram_o(sir), .dst_valid_o(dv), .dst_ready_i(dre),
    .dst_data_o(dd), .dst_addr_o(da), .dst_is_ram_o(dri),
    .block_event_o(ev));
  dmacl_far far (.clk_i(clk_i), .reset_i(reset_i), .load_i(ld),
    .count_i(cnt), .src_ready_i(sr), .src_valid_o(sv),
    .src_data_o(sd), .dst_ready_o(dre), .left_o(left));
  // ==================================================
  // checking
  task report_and_stop;
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_dma(input logic [23:0] g, input logic [23:0] e);
    chk_reg({10'h0, g}, {10'h0, e});
  endtask
  task hang;
    errors++;
    report_and_stop();
  endtask
  always @(negedge clk_i)
  begin
    if (rv && rre)
      chk_reg({rr, rdat}, rq.pop_front());
    if (bv && bre)
      chk_reg({32'h0, br}, {32'h0, bq.pop_front()});
    if (ev)
      chk_dma(24'(mv % n), half ? 24'(n / 2) : 24'h0);
    evn += int'(ev);
    if (sv && sr)
    begin
      dq.push_back(sd);
      chk_dma(sa, dir ? aq[0] : pa);
      chk_dma({23'h0, sir}, {23'h0, dir});
      if (dir)
        la = aq.pop_front();
    end
    if (dv && dre)
    begin
      chk_dma({8'h0, dd}, {8'h0, dq.pop_front()});
      chk_dma(da, dir ? pa : aq[0]);
      chk_dma({23'h0, dri}, {23'h0, !dir});
      if (!dir)
        la = aq.pop_front();
      mv++;
    end
  end
  // ==================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = RESP_OKAY);
    logic aw, w, b;
    int i;
    @(posedge clk_i);
    bq.push_back(e);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    for (i = 0; i < 99; i++)
    begin
      @(negedge clk_i);
      aw = awr; w = wr_; b = bv;
      @(posedge clk_i);
      if (aw) awv <= 0;
      if (w) wv <= 0;
      if (b) break;
    end
    bre <= 0;
    if (i == 99) hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic t, r;
    int i;
    @(posedge clk_i);
    rq.push_back(e); ara <= a; arv <= 1; rre <= 1;
    for (i = 0; i < 99; i++)
    begin
      @(negedge clk_i);
      t = arr; r = rv;
      @(posedge clk_i);
      if (t) arv <= 0;
      if (r) break;
    end
    rre <= 0;
    if (i == 99) hang();
  endtask
  // ==================================================
  // one channel run in mode m
  task automatic run(input logic [1:0] m, input int nb);
    int b, i;
    dir = 1'($urandom); half = 1'($urandom);
    ba = 24'($urandom) & 24'hfffffe; bb = 24'($urandom) & 24'hfffffe;
    pa = {8'h0, 16'($urandom)}; mv = 0; evn = 0; n = 4;
    for (b = 0; b < nb; b++)
      for (i = 0; i < n; i++)
        aq.push_back((m[1] && b[0] ? bb : ba) + 24'(2 * i));
    wr(OFF_BUFA, {8'h0, ba});
    wr(OFF_BUFB, {8'h0, bb});
    wr(OFF_PERI, {8'h0, pa});
    wr(OFF_CNT, 32'(n - 1));
    @(posedge clk_i);
    cnt <= 8'(n * nb); ld <= 1;
    @(posedge clk_i);
    ld <= 0;
    wr(OFF_CTRL, {16'h0, 2'b10, dir, half, 10'h0, m});
    for (i = 0; i < 999 && (left != 0 || dq.size() != 0 || evn < nb); i++)
      @(posedge clk_i);
    if (i == 999) hang();
    rd(OFF_CTRL, {18'h0, !m[0], 1'b0, dir, half, 10'h0, m});
    wr(OFF_LAST_LO, 32'hffffffff);
    rd(OFF_LAST_HI, {26'h0, la[23:16]});
    rd(OFF_LAST_LO, {18'h0, la[15:0]});
    chk_dma(24'(evn), 24'(nb));
    wr(OFF_CTRL, 32'h0);
  endtask
  initial
  begin
    void'($urandom(27050));
    repeat (4) @(posedge clk_i);
    reset_i <= 0;
    rd(OFF_LAST_HI, 34'h0);
    rd(OFF_LAST_LO, 34'h0);
    rd(8'h20, {RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h1, RESP_SLVERR);
    for (k = 0; k < 8; k++)
      run(2'(k), k % 4 == 1 ? 1 : k % 4 == 3 ? 2 : 3);
    report_and_stop();
  end
endmodule // dmacl_top_test
